// ==== rtl/tccc_map.vh ====
// register map, field positions and reset values of the capture/compare counter
`ifndef TCCC_MAP_VH
`define TCCC_MAP_VH
`define TCCC_MAIN_CTRL    12'h000
`define TCCC_COUNT_HIGH   12'h004
`define TCCC_COUNT_LOW    12'h008
`define TCCC_LIMIT_HIGH   12'h00C
`define TCCC_LIMIT_LOW    12'h010
`define TCCC_CH0_CTRL     12'h014
`define TCCC_CH0_VAL_HIGH 12'h018
`define TCCC_CH0_VAL_LOW  12'h01C
`define TCCC_CH1_CTRL     12'h020
`define TCCC_CH1_VAL_HIGH 12'h024
`define TCCC_CH1_VAL_LOW  12'h028
`define TCCC_IRQ_STATUS   12'h02C
`define TCCC_F_WRAP_FLAG  7
`define TCCC_F_WRAP_IE    6
`define TCCC_F_HALT       5
`define TCCC_F_CLEAR      4
`define TCCC_F_CH_FLAG    7
`define TCCC_F_CH_IE      6
`define TCCC_F_CH_MSB     5
`define TCCC_F_CH_MSA     4
`define TCCC_F_CH_ELSB    3
`define TCCC_F_CH_ELSA    2
`define TCCC_F_CH_TOV     1
`define TCCC_F_CH_MAX     0
`define TCCC_MAIN_RESET   8'h20
`define TCCC_LIMIT_RESET  16'hFFFF
`define TCCC_EXT_CLK_SEL  3'h7
`endif

// ==== rtl/tccc_top.v ====
// two-channel capture/compare counter with apb register access
// Functional notes
// - wrap flag sets when count equals limit
// - flag clears by read-then-zero-write sequence
// - new wrap voids clear; writing one ignored
// - wrap interrupt requested when enabled and set, except while limit half-written
// - halt holds count; reset sets halt
// - halt inhibits input captures
// - clear bit zeros counter and prescaler
// - halt plus clear stops at zero
// - clock select: divide 1..64 or external
// - high read latches low byte
// - counter restarts at zero after limit
// - limit high write blocks wrap flag
// - limit resets to all ones
// - channel flag on edge or match
// - channel flag read-then-zero clear sequence
// - channel interrupt when flag and enable
// - pair link ignores channel 1 control
// - mode bit: compare/capture or initial level
// - capture edges rising, falling, both
// - compare pin action toggle, low, high
// - edge/level 00 releases pin to port
// - toggle on wrap, wrap beats match
// - full duty bit with toggle-on-wrap forces 100% next period
// - value high write blocks compares
// - value high read blocks captures
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "tccc_map.vh"
module tccc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        external_count_clock_pin,
  input  wire [1:0]  channel_pin_in,
  output reg  [1:0]  channel_pin_out,
  output reg  [1:0]  channel_pin_oe,
  output reg         wrap_irq,
  output reg  [1:0]  channel_irq
);
  reg  [7:0]  main_ctrl;
  reg  [2:0]  clock_select_field;
  reg  [15:0] count;
  reg  [5:0]  prescale;
  reg  [15:0] limit;
  reg  [7:0]  limit_high_buf;
  reg         limit_block;
  reg  [7:0]  low_latch;
  reg         low_latched;
  reg         wrap_armed;
  reg         ext_prev;
  reg  [7:0]  ch_ctrl [0:1];
  reg  [15:0] ch_val [0:1];
  reg  [7:0]  ch_high_buf [0:1];
  reg  [1:0]  ch_block;
  reg  [1:0]  ch_armed;
  reg  [1:0]  pin_prev;
  reg  [1:0]  pin_level;
  reg  [1:0]  max_active;
  reg         active_ch;
  reg         ch1_pending;
  reg  [31:0] next_rdata;
  reg         next_err;
  wire        acc;
  wire        wr;
  wire        rd;
  wire        tick;
  wire        at_limit;
  wire        wrap_evt;
  wire        linked;
  reg         tick_src;
  integer     i;
  assign acc = psel & penable & ~pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign linked = ch_ctrl[0][`TCCC_F_CH_MSB];

  function [7:0] sel8;
    input [15:0] v;
    input        hi;
    begin
      sel8 = hi ? v[15:8] : v[7:0];
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  always @* begin
    case (clock_select_field)
      3'h0:    tick_src = 1'b1;
      3'h1:    tick_src = (prescale[0] == 1'b1);
      3'h2:    tick_src = (prescale[1:0] == 2'h3);
      3'h3:    tick_src = (prescale[2:0] == 3'h7);
      3'h4:    tick_src = (prescale[3:0] == 4'hF);
      3'h5:    tick_src = (prescale[4:0] == 5'h1F);
      3'h6:    tick_src = (prescale == 6'h3F);
      default: tick_src = external_count_clock_pin & ~ext_prev;
    endcase
  end
  assign tick = tick_src & ~main_ctrl[`TCCC_F_HALT];
  assign at_limit = (count == limit);
  // wrap flag suppressed while limit half-written
  assign wrap_evt = tick & at_limit & ~limit_block;

  // read mux
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr)
      `TCCC_MAIN_CTRL:    next_rdata[7:0] = {main_ctrl[7:5], 2'b00, clock_select_field};
      `TCCC_COUNT_HIGH:   next_rdata[7:0] = count[15:8];
      `TCCC_COUNT_LOW:    next_rdata[7:0] = low_latched ? low_latch : count[7:0];
      `TCCC_LIMIT_HIGH:   next_rdata[7:0] = limit[15:8];
      `TCCC_LIMIT_LOW:    next_rdata[7:0] = limit[7:0];
      `TCCC_CH0_CTRL:     next_rdata[7:0] = ch_ctrl[0];
      `TCCC_CH0_VAL_HIGH: next_rdata[7:0] = sel8(ch_val[0], 1'b1);
      `TCCC_CH0_VAL_LOW:  next_rdata[7:0] = sel8(ch_val[0], 1'b0);
      `TCCC_CH1_CTRL:     next_rdata[7:0] = ch_ctrl[1];
      `TCCC_CH1_VAL_HIGH: next_rdata[7:0] = sel8(ch_val[1], 1'b1);
      `TCCC_CH1_VAL_LOW:  next_rdata[7:0] = sel8(ch_val[1], 1'b0);
      `TCCC_IRQ_STATUS:   next_rdata[7:0] = {5'h00, channel_irq, wrap_irq};
      default:            next_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_err;
      if (rd)
        prdata <= next_rdata;
    end
  end

  // counter, main control, limit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ctrl          <= `TCCC_MAIN_RESET;
      clock_select_field <= 3'h0;
      count              <= 16'h0000;
      prescale           <= 6'h00;
      limit              <= `TCCC_LIMIT_RESET;
      limit_high_buf     <= 8'hFF;
      limit_block        <= 1'b0;
      low_latch          <= 8'h00;
      low_latched        <= 1'b0;
      wrap_armed         <= 1'b0;
      ext_prev           <= 1'b0;
      wrap_irq           <= 1'b0;
    end else begin
      ext_prev <= external_count_clock_pin;
      if (!main_ctrl[`TCCC_F_HALT])
        prescale <= prescale + 6'h01;
      if (tick) begin
        if (at_limit)
          count <= 16'h0000;
        else
          count <= count + 16'h0001;
      end
      // arm clear on read with flag set
      if (rd && hit(paddr, `TCCC_MAIN_CTRL) && main_ctrl[`TCCC_F_WRAP_FLAG])
        wrap_armed <= 1'b1;
      if (wr && hit(paddr, `TCCC_MAIN_CTRL)) begin
        main_ctrl[`TCCC_F_WRAP_IE] <= pwdata[`TCCC_F_WRAP_IE];
        main_ctrl[`TCCC_F_HALT]    <= pwdata[`TCCC_F_HALT];
        clock_select_field         <= pwdata[2:0];
        // zero write clears only if armed
        if (!pwdata[`TCCC_F_WRAP_FLAG] && wrap_armed)
          main_ctrl[`TCCC_F_WRAP_FLAG] <= 1'b0;
        wrap_armed <= 1'b0;
        if (pwdata[`TCCC_F_CLEAR]) begin
          // halt plus clear stops at zero
          count    <= 16'h0000;
          prescale <= 6'h00;
        end
      end
      if (wrap_evt) begin
        main_ctrl[`TCCC_F_WRAP_FLAG] <= 1'b1;
        wrap_armed <= 1'b0;
      end
      // high read latches low byte once
      if (rd && hit(paddr, `TCCC_COUNT_HIGH) && !low_latched) begin
        low_latch   <= count[7:0];
        low_latched <= 1'b1;
      end
      if (rd && hit(paddr, `TCCC_COUNT_LOW))
        low_latched <= 1'b0;
      if (wr && hit(paddr, `TCCC_MAIN_CTRL) && pwdata[`TCCC_F_CLEAR]) begin
        low_latch   <= 8'h00;
        low_latched <= 1'b0;
      end
      // high write blocks until low written
      if (wr && hit(paddr, `TCCC_LIMIT_HIGH)) begin
        limit_high_buf <= pwdata[7:0];
        limit_block    <= 1'b1;
      end
      if (wr && hit(paddr, `TCCC_LIMIT_LOW)) begin
        limit       <= {limit_high_buf, pwdata[7:0]};
        limit_block <= 1'b0;
      end
      wrap_irq <= main_ctrl[`TCCC_F_WRAP_IE] & main_ctrl[`TCCC_F_WRAP_FLAG] & ~limit_block;
    end
  end

  // channels
  reg [1:0] cap_evt;
  reg [1:0] cmp_evt;
  reg [1:0] ch_on;
  reg [1:0] is_cmp;
  reg [7:0] cfg [0:1];
  integer   c;
  always @* begin
    for (c = 0; c < 2; c = c + 1) begin
      cfg[c]    = (c == 1 && linked) ? 8'h00 : ch_ctrl[c];
      ch_on[c]  = cfg[c][`TCCC_F_CH_ELSB] | cfg[c][`TCCC_F_CH_ELSA];
      // mode bit selects compare or capture
      is_cmp[c] = cfg[c][`TCCC_F_CH_MSA] | (c == 0 && linked);
      cap_evt[c] = ~is_cmp[c] & ch_on[c] & ~main_ctrl[`TCCC_F_HALT] & ~ch_block[c] &
                   ((cfg[c][`TCCC_F_CH_ELSA] & channel_pin_in[c] & ~pin_prev[c]) |
                    (cfg[c][`TCCC_F_CH_ELSB] & ~channel_pin_in[c] & pin_prev[c]));
      cmp_evt[c] = is_cmp[c] & ~ch_block[c] & tick &
                   (count == ((c == 0 && linked) ? ch_val[active_ch] : ch_val[c]));
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 2; i = i + 1) begin
        ch_ctrl[i]     <= 8'h00;
        ch_val[i]      <= 16'h0000;
        ch_high_buf[i] <= 8'h00;
      end
      ch_block        <= 2'b00;
      ch_armed        <= 2'b00;
      pin_prev        <= 2'b00;
      pin_level       <= 2'b00;
      max_active      <= 2'b00;
      active_ch       <= 1'b0;
      ch1_pending     <= 1'b0;
      channel_pin_out <= 2'b00;
      channel_pin_oe  <= 2'b00;
      channel_irq     <= 2'b00;
    end else begin
      pin_prev <= channel_pin_in;
      // buffered pair swaps to last written set at wrap
      if (wrap_evt && linked && ch1_pending) begin
        active_ch   <= ~active_ch;
        ch1_pending <= 1'b0;
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (rd && hit(paddr, (i == 0) ? `TCCC_CH0_CTRL : `TCCC_CH1_CTRL) &&
            ch_ctrl[i][`TCCC_F_CH_FLAG])
          ch_armed[i] <= 1'b1;
        if (wr && hit(paddr, (i == 0) ? `TCCC_CH0_CTRL : `TCCC_CH1_CTRL)) begin
          ch_ctrl[i][6:0] <= (i == 0) ? pwdata[6:0] : {pwdata[6], 1'b0, pwdata[4:0]};
          if (!pwdata[`TCCC_F_CH_FLAG] && ch_armed[i])
            ch_ctrl[i][`TCCC_F_CH_FLAG] <= 1'b0;
          ch_armed[i] <= 1'b0;
          // preset level when edge/level is 00
          if (pwdata[3:2] == 2'b00)
            pin_level[i] <= ~pwdata[`TCCC_F_CH_MSA];
        end
        if (wr && hit(paddr, (i == 0) ? `TCCC_CH0_VAL_HIGH : `TCCC_CH1_VAL_HIGH)) begin
          ch_high_buf[i] <= pwdata[7:0];
          if (is_cmp[i])
            ch_block[i] <= 1'b1;
        end
        if (wr && hit(paddr, (i == 0) ? `TCCC_CH0_VAL_LOW : `TCCC_CH1_VAL_LOW)) begin
          ch_val[i]   <= {ch_high_buf[i], pwdata[7:0]};
          ch_block[i] <= 1'b0;
          if (linked)
            ch1_pending <= (i[0] != active_ch);
        end
        if (rd && hit(paddr, (i == 0) ? `TCCC_CH0_VAL_HIGH : `TCCC_CH1_VAL_HIGH) &&
            !is_cmp[i])
          ch_block[i] <= 1'b1;
        if (rd && hit(paddr, (i == 0) ? `TCCC_CH0_VAL_LOW : `TCCC_CH1_VAL_LOW) && !is_cmp[i])
          ch_block[i] <= 1'b0;
        if (cap_evt[i])
          ch_val[i] <= count;
        // full duty latched at period start
        if (wrap_evt)
          max_active[i] <= cfg[i][`TCCC_F_CH_MAX];
        if (is_cmp[i] && ch_on[i] && wrap_evt && cfg[i][`TCCC_F_CH_TOV])
          pin_level[i] <= ~pin_level[i];
        else if (cmp_evt[i] && ch_on[i] && !(cfg[i][`TCCC_F_CH_TOV] && max_active[i])) begin
          case (cfg[i][3:2])
            2'b01:   pin_level[i] <= ~pin_level[i];
            2'b10:   pin_level[i] <= 1'b0;
            2'b11:   pin_level[i] <= 1'b1;
            default: pin_level[i] <= pin_level[i];
          endcase
        end
        if (cap_evt[i] || cmp_evt[i]) begin
          ch_ctrl[i][`TCCC_F_CH_FLAG] <= 1'b1;
          ch_armed[i] <= 1'b0;
        end
        channel_pin_oe[i]  <= is_cmp[i] & ch_on[i];
        channel_pin_out[i] <= (cfg[i][`TCCC_F_CH_TOV] & max_active[i]) ? 1'b1 : pin_level[i];
        channel_irq[i] <= cfg[i][`TCCC_F_CH_FLAG] & cfg[i][`TCCC_F_CH_IE];
      end
    end
  end
endmodule

// ==== testbench/tccc_properties.sv ====
// checker on the apb answers, interrupt drops and pin enables
`timescale 1ns/100ps
module tccc_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        external_count_clock_pin,
  input wire [1:0]  channel_pin_in,
  input wire [1:0]  channel_pin_out,
  input wire [1:0]  channel_pin_oe,
  input wire        wrap_irq,
  input wire [1:0]  channel_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wrt = psel && pwrite;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_follows: assert property (acc && !pready |=> pready)
    else $error("pready late");
  a_ready_cause: assert property (pready |-> $past(acc))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_oe_by_write: assert property (
    $changed(channel_pin_oe) |-> $past(wrt) || $past(wrt, 2))
    else $error("pin enable moved without a write");
  a_wrap_irq_drop: assert property (
    $fell(wrap_irq) |-> $past(wrt) || $past(wrt, 2))
    else $error("wrap irq dropped without a write");
  a_ch_irq_drop: assert property (
    |($past(channel_irq) & ~channel_irq) |-> $past(wrt) || $past(wrt, 2))
    else $error("channel irq dropped without a write");
  c_refused: cover property (pslverr);
  c_wrap: cover property ($rose(wrap_irq));
  c_ch0: cover property ($rose(channel_irq[0]));
  c_ch1: cover property ($rose(channel_irq[1]));
endmodule
bind tccc_top tccc_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_count_clock_pin(external_count_clock_pin), .channel_pin_in(channel_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .wrap_irq(wrap_irq), .channel_irq(channel_irq));

// ==== testbench/tb_top.sv ====
// self-checking bench for the capture/compare counter
`timescale 1ns/100ps
`include "tccc_map.vh"
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, ext, p;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdat;
  reg  [1:0]  pin;
  reg  [15:0] cnt;
  wire [31:0] prdata;
  wire        pready, pslverr, wrap_irq;
  wire [1:0]  pout, poe, chirq;
  reg  [32:0] eq[$];
  reg         mq[$];
  integer     bad_count, num_checks, seed, i, k, n, x;
  tccc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock_pin(ext), .channel_pin_in(pin),
    .channel_pin_out(pout), .channel_pin_oe(poe), .wrap_irq(wrap_irq), .channel_irq(chirq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always begin
    repeat (5) @(posedge pclk);
    ext <= ~ext;
  end
  task chk(input [32:0] s, input [32:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task xfer(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    xfer(1'b1, a, d);
  endtask
  // expected read noted before the bus cycle
  task rd(input [11:0] a, input [7:0] e, input m);
    begin
      eq.push_back({a > `TCCC_IRQ_STATUS, 24'h0, e});
      mq.push_back(m);
      xfer(1'b0, a, 8'h0);
    end
  endtask
  always @(posedge pclk)
    if (pready === 1'b1 && psel && !pwrite && eq.size() > 0) begin
      if (mq[0])
        chk({pslverr, prdata}, eq[0]);
      eq.pop_front();
      mq.pop_front();
    end
  function sig(input [1:0] s);
    sig = (s == 2'd0) ? wrap_irq : chirq[s - 2'd1];
  endfunction
  task wt(input [1:0] s, input e);
    begin
      for (n = 0; n < 400 && sig(s) !== e; n = n + 1) @(posedge pclk);
      chk(sig(s), e);
    end
  endtask
  task settle(input integer c);
    begin
      repeat (c) @(posedge pclk);
      #1;
    end
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    seed = 32'he52c;
    bad_count = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata, pin, ext, presetn} = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TCCC_MAIN_CTRL, 8'h20, 1); // halted
    rd(`TCCC_LIMIT_HIGH, 8'hFF, 1); // ones
    rd(`TCCC_LIMIT_LOW, 8'hFF, 1); // ones
    rd(`TCCC_COUNT_HIGH, 8'h00, 1); // zero
    rd(`TCCC_CH0_CTRL, 8'h00, 1);
    rd(12'h030, 8'h00, 1);
    $display("reset values done");
    for (k = 0; k < 8; k = k + 1) begin
      wr(`TCCC_MAIN_CTRL, 8'h30);
      wr(`TCCC_MAIN_CTRL, k[7:0]);
      repeat (640) @(posedge pclk);
      wr(`TCCC_MAIN_CTRL, 8'h20);
      rd(`TCCC_COUNT_HIGH, 8'h00, 0);
      i = rdat;
      rd(`TCCC_COUNT_LOW, 8'h00, 0);
      cnt = {i[7:0], rdat[7:0]};
      x = (k == 7) ? 64 : 640 >> k;
      chk(cnt + 2 >= x && cnt <= x + 6, 1); // rate
    end
    wr(`TCCC_MAIN_CTRL, 8'h30);
    rd(`TCCC_MAIN_CTRL, 8'h20, 1); // reads zero
    rd(`TCCC_COUNT_HIGH, 8'h00, 1); // zero
    rd(`TCCC_COUNT_LOW, 8'h00, 1); // zero
    $display("clock select done");
    wr(`TCCC_LIMIT_HIGH, 8'h00);
    wr(`TCCC_LIMIT_LOW, 8'h05);
    wr(`TCCC_MAIN_CTRL, 8'h40);
    wt(0, 1); // wrap
    wr(`TCCC_MAIN_CTRL, 8'hE0);
    wr(`TCCC_MAIN_CTRL, 8'h60);
    chk(wrap_irq, 1); // kept
    rd(`TCCC_MAIN_CTRL, 8'hE0, 1); // set
    wr(`TCCC_MAIN_CTRL, 8'h70);
    wt(0, 0); // cleared
    wr(`TCCC_LIMIT_HIGH, 8'h00);
    wr(`TCCC_MAIN_CTRL, 8'h40);
    settle(100);
    chk(wrap_irq, 0); // held off
    wr(`TCCC_LIMIT_LOW, 8'h05);
    wt(0, 1); // released
    wr(`TCCC_MAIN_CTRL, 8'h60);
    rd(`TCCC_MAIN_CTRL, 8'hE0, 1); // wrapped
    wr(`TCCC_MAIN_CTRL, 8'h00);
    wt(0, 0); // cleared
    settle(20);
    chk(wrap_irq, 0); // disabled
    rd(`TCCC_MAIN_CTRL, 8'h80, 1); // set again
    $display("wrap done");
    wr(`TCCC_MAIN_CTRL, 8'h30);
    wr(`TCCC_LIMIT_LOW, 8'h40);
    cnt = 8 + ($random(seed) & 15);
    wr(`TCCC_CH0_VAL_HIGH, 8'h00);
    wr(`TCCC_CH0_VAL_LOW, cnt[7:0]);
    for (k = 1; k < 4; k = k + 1) begin
      wr(`TCCC_MAIN_CTRL, 8'h30); // halt and clear
      wr(`TCCC_CH0_CTRL, {4'h5, k[1:0], 2'b00});
      settle(2);
      p = pout[0];
      chk(poe[0], 1); // driven
      wr(`TCCC_MAIN_CTRL, 8'h00);
      wt(1, 1); // match
      settle(2);
      chk(pout[0], (k == 1) ? !p : (k == 3)); // action
      wr(`TCCC_MAIN_CTRL, 8'h20);
      rd(`TCCC_CH0_CTRL, {4'hD, k[1:0], 2'b00}, 1); // set
      wr(`TCCC_CH0_CTRL, {4'h5, k[1:0], 2'b00});
      wt(1, 0); // cleared
    end
    // pwm: high from wrap to match, then forced full duty
    wr(`TCCC_MAIN_CTRL, 8'h30);
    wr(`TCCC_CH0_CTRL, 8'h1A);
    wr(`TCCC_MAIN_CTRL, 8'h00);
    for (k = 0; k < 2; k = k + 1) begin
      settle(200);
      x = 0;
      repeat (130) begin
        settle(1);
        x = x + pout[0];
      end
      chk(x, k ? 130 : 2 * cnt + 2); // duty
      wr(`TCCC_CH0_CTRL, 8'h1B);
    end
    wr(`TCCC_CH0_CTRL, 8'h50);
    settle(2);
    chk(poe[0], 0); // released
    $display("compare done");
    for (k = 1; k < 4; k = k + 1) begin
      wr(`TCCC_MAIN_CTRL, 8'h30);
      rd(`TCCC_CH1_CTRL, 8'h00, 0);
      wr(`TCCC_CH1_CTRL, {4'h4, k[1:0], 2'b00});
      pin[1] <= 1'b1;
      settle(10);
      chk(chirq[1], 0); // halted
      wr(`TCCC_MAIN_CTRL, 8'h00);
      pin[1] <= 1'b0;
      settle(10);
      chk(chirq[1], k[1]); // falling
      rd(`TCCC_CH1_CTRL, 8'h00, 0);
      wr(`TCCC_CH1_CTRL, {4'h4, k[1:0], 2'b00});
      pin[1] <= 1'b1;
      settle(10);
      chk(chirq[1], k[0]); // rising
    end
    wr(`TCCC_CH1_CTRL, 8'h00);
    settle(2);
    chk(pout[1], 1); // preset high
    wr(`TCCC_CH1_CTRL, 8'h10);
    settle(2);
    chk(pout[1], 0); // preset low
    wr(`TCCC_CH0_CTRL, 8'h20);
    wr(`TCCC_CH1_CTRL, 8'h5C);
    settle(2);
    chk({poe[1], chirq[1]}, 0); // ignored
    $display("capture and link done");
    final_report;
  end
endmodule
